/* File: ubrg_pkg.sv */
package ubrg_pkg;
    // register byte offsets on the axi4-lite slave
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_MODE = 5'h00;
    localparam logic [4:0] OFS_CLKSEL = 5'h04;
    localparam logic [4:0] OFS_DIV = 5'h08;
    localparam logic [4:0] OFS_TXBUF = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_RXDATA = 5'h14;
    // serial_mode_reg field positions
    localparam int MODE_POWER_BIT = 7;
    localparam int MODE_TXE_BIT = 6;
    localparam int MODE_RXE_BIT = 5;
    // status register field positions
    localparam int ST_RX_VALID = 0;
    localparam int ST_STOP_OK = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_RX_BUSY = 3;
    localparam int ST_TX_PEND = 4;
    // widths and limits
    localparam int SEL_W = 4;
    localparam int K_W = 8;
    localparam int PRE_W = 10;
    localparam logic [3:0] SEL_MAX = 4'ha;
    localparam logic [3:0] FRAME_BITS = 4'hb;
    localparam logic [1:0] GAP_CLKS = 2'h2;
    // reset values
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [7:0] K_RESET = 8'hff;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic power;
        logic txe;
        logic rxe;
        logic [SEL_W-1:0] sel;
        logic [K_W-1:0] k;
    } ubrg_cfg_t;

    typedef enum {TX_IDLE, TX_GAP, TX_SHIFT} ubrg_tx_state_t;
    typedef enum {RX_IDLE, RX_BUSY} ubrg_rx_state_t;
endpackage

/* File: ubrg_prescaler.sv */
module ubrg_prescaler
    import ubrg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic power,
    input wire logic [SEL_W-1:0] sel,
    // base clock enable
    output logic base_en
);
    logic [PRE_W-1:0] cnt_reg;
    logic [SEL_W-1:0] sel_c;
    logic [PRE_W-1:0] mask;
    logic hit;

    // codes above the top tap clamp to the slowest rate
    assign sel_c = (sel > SEL_MAX) ? SEL_MAX : sel;
    assign mask = (PRE_W'(1) << sel_c) - PRE_W'(1);
    assign hit = (cnt_reg & mask) == mask;

    // base clock is held low while powered down
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            base_en <= 1'b0;
        end else if (!power) begin
            cnt_reg <= '0;
            base_en <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + PRE_W'(1);
            base_en <= hit;
        end
    end
endmodule

/* File: ubrg_divider.sv */
module ubrg_divider
    import ubrg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic base_en,
    input wire logic [K_W-1:0] k,
    // half-bit tick
    output logic half_tick
);
    logic [K_W-1:0] cnt_reg;
    logic wrap;

    // k of zero wraps after 256 base clocks
    assign wrap = cnt_reg == (k - 8'h01);

    // counts k base clocks per half bit, two halves per bit
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            half_tick <= 1'b0;
        end else if (!run || clear) begin
            cnt_reg <= '0;
            half_tick <= 1'b0;
        end else if (base_en) begin
            cnt_reg <= wrap ? '0 : cnt_reg + 8'h01;
            half_tick <= wrap;
        end else begin
            half_tick <= 1'b0;
        end
    end
endmodule

/* File: ubrg_top.sv */
module ubrg_top
    import ubrg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // serial pins and timing strobes
    input wire logic rxd,
    output logic txd,
    output logic base_tick,
    output logic tx_half_tick,
    output logic rx_half_tick,
    output logic rx_sample
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == OFS_MODE) || (a == OFS_CLKSEL) || (a == OFS_DIV) ||
                      (a == OFS_TXBUF) || (a == OFS_STATUS) || (a == OFS_RXDATA);
    endfunction

    ubrg_cfg_t cfg_reg;
    logic aw_full_reg, w_full_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic wr_fire, wr_en, wr_txbuf, wr_status;
    logic [31:0] rd_word;
    logic [7:0] mode_byte;
    logic [4:0] status_bits;

    logic tx_run, rx_run, tx_start;
    ubrg_tx_state_t tx_state_reg;
    logic tx_pend_reg;
    logic [7:0] tx_buf_reg;
    logic [9:0] tx_sh_reg;
    logic [3:0] tx_bit_reg;
    logic tx_phase_reg;
    logic [1:0] gap_reg;
    logic gap_done;

    ubrg_rx_state_t rx_state_reg;
    logic rxd_meta_reg, rxd_sync_reg, samp_reg, filt_reg, filt_prev_reg, base_prev_reg;
    logic rx_go, rx_take;
    logic rx_phase_reg;
    logic [3:0] rx_bit_reg;
    logic [10:0] rx_sh_reg;
    logic [7:0] rx_data_reg;
    logic rx_valid_reg, stop_ok_reg;

    ////////////////////////////////////////////////////////////////////////
    // write path decode: both halves held, then one write at a time
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_en = wr_fire && wstrb0_reg;
    assign wr_txbuf = wr_en && (awaddr_reg == OFS_TXBUF);
    assign wr_status = wr_en && (awaddr_reg == OFS_STATUS);

    // write address and data channels taken in either order
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
                w_full_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control registers; registers are byte wide, only lane 0 counts
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= '{power: 1'b0, txe: 1'b0, rxe: 1'b0, sel: SEL_RESET, k: K_RESET};
        end else if (wr_en) begin
            if (awaddr_reg == OFS_MODE) begin
                cfg_reg.power <= wdata_reg[MODE_POWER_BIT];
                cfg_reg.txe <= wdata_reg[MODE_TXE_BIT];
                cfg_reg.rxe <= wdata_reg[MODE_RXE_BIT];
            end
            if (awaddr_reg == OFS_CLKSEL) begin
                cfg_reg.sel <= wdata_reg[SEL_W-1:0];
            end
            if (awaddr_reg == OFS_DIV) begin
                cfg_reg.k <= wdata_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    assign mode_byte = {cfg_reg.power, cfg_reg.txe, cfg_reg.rxe, 5'h00};
    assign status_bits = {tx_pend_reg, rx_state_reg == RX_BUSY, tx_state_reg != TX_IDLE,
                          stop_ok_reg, rx_valid_reg};
    assign rd_word = (s_axi_araddr == OFS_MODE) ? {24'h000000, mode_byte} :
                     (s_axi_araddr == OFS_CLKSEL) ? {28'h0000000, cfg_reg.sel} :
                     (s_axi_araddr == OFS_DIV) ? {24'h000000, cfg_reg.k} :
                     (s_axi_araddr == OFS_TXBUF) ? {24'h000000, tx_buf_reg} :
                     (s_axi_araddr == OFS_STATUS) ? {27'h0000000, status_bits} :
                     (s_axi_araddr == OFS_RXDATA) ? {24'h000000, rx_data_reg} : 32'h00000000;

    // one read at a time; data captured with the address
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base clock and the two dividers
    assign tx_run = cfg_reg.power && cfg_reg.txe;
    assign rx_run = cfg_reg.power && cfg_reg.rxe;

    ubrg_prescaler u_pre (
        .sys_clk(sys_clk),
        .reset(reset),
        .power(cfg_reg.power),
        .sel(cfg_reg.sel),
        .base_en(base_tick)
    );

    // tx counter restarts on every frame start, otherwise free-runs
    ubrg_divider u_tx_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(tx_run),
        .clear(tx_start),
        .base_en(base_tick),
        .k(cfg_reg.k),
        .half_tick(tx_half_tick)
    );

    // rx counter only runs inside a frame
    ubrg_divider u_rx_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(rx_run && (rx_state_reg == RX_BUSY)),
        .clear(rx_go),
        .base_en(base_tick),
        .k(cfg_reg.k),
        .half_tick(rx_half_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit sequencing
    assign gap_done = (tx_state_reg == TX_GAP) && (gap_reg == GAP_CLKS);
    // a start from idle waits for the clock after a base tick, the phase a chained start has,
    // so the first frame's bits are as long as the later ones
    assign tx_start = tx_run && (((tx_state_reg == TX_IDLE) && tx_pend_reg && base_prev_reg) || gap_done);

    // one pending byte; a write while full is dropped unless a frame starts in that cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_pend_reg <= 1'b0;
            tx_buf_reg <= '0;
        end else if (!cfg_reg.power) begin
            tx_pend_reg <= 1'b0;
        end else if (wr_txbuf && (!tx_pend_reg || tx_start)) begin
            tx_pend_reg <= 1'b1;
            tx_buf_reg <= wdata_reg;
        end else if (tx_start) begin
            tx_pend_reg <= 1'b0;
        end
    end

    // start, 8 data lsb first, even parity, stop; new bit every 2 ticks
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_state_reg <= TX_IDLE;
            txd <= 1'b1;
            tx_sh_reg <= '0;
            tx_bit_reg <= '0;
            tx_phase_reg <= 1'b0;
            gap_reg <= '0;
        end else if (!tx_run) begin
            tx_state_reg <= TX_IDLE;
            txd <= 1'b1;
        end else if (tx_start) begin
            tx_state_reg <= TX_SHIFT;
            txd <= 1'b0;
            tx_sh_reg <= {1'b1, ^tx_buf_reg, tx_buf_reg};
            tx_bit_reg <= '0;
            tx_phase_reg <= 1'b0;
        end else begin
            unique case (tx_state_reg)
                TX_IDLE: begin
                    txd <= 1'b1;
                end
                TX_GAP: begin
                    if (base_tick) begin
                        gap_reg <= gap_reg + 2'h1;
                    end
                end
                TX_SHIFT: begin
                    if (tx_half_tick) begin
                        tx_phase_reg <= !tx_phase_reg;
                        if (tx_phase_reg && (tx_bit_reg == FRAME_BITS - 4'h1)) begin
                            // stop bit done: chain or fall idle
                            tx_state_reg <= tx_pend_reg ? TX_GAP : TX_IDLE;
                            gap_reg <= '0;
                            txd <= 1'b1;
                        end else if (tx_phase_reg) begin
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                            txd <= tx_sh_reg[0];
                            tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rxd crossing and match filter; the filter adds the two-clock margin
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
            samp_reg <= 1'b1;
            filt_reg <= 1'b1;
            filt_prev_reg <= 1'b1;
            base_prev_reg <= 1'b0;
        end else begin
            base_prev_reg <= base_tick;
            rxd_meta_reg <= rxd;
            rxd_sync_reg <= rxd_meta_reg;
            filt_prev_reg <= filt_reg;
            if (!cfg_reg.power) begin
                samp_reg <= 1'b1;
                filt_reg <= 1'b1;
            end else if (base_tick) begin
                samp_reg <= rxd_sync_reg;
                if (samp_reg == rxd_sync_reg) begin
                    filt_reg <= samp_reg;
                end
            end
        end
    end

    // receive sequencing; first tick lands mid start bit
    assign rx_go = rx_run && (rx_state_reg == RX_IDLE) && filt_prev_reg && !filt_reg;
    assign rx_take = rx_half_tick && !rx_phase_reg;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_state_reg <= RX_IDLE;
            rx_phase_reg <= 1'b0;
            rx_bit_reg <= '0;
            rx_sh_reg <= '0;
            rx_data_reg <= '0;
            stop_ok_reg <= 1'b0;
            rx_sample <= 1'b0;
        end else begin
            rx_sample <= rx_take;
            if (!rx_run) begin
                rx_state_reg <= RX_IDLE;
            end else if (rx_go) begin
                rx_state_reg <= RX_BUSY;
                rx_phase_reg <= 1'b0;
                rx_bit_reg <= '0;
            end else if (rx_state_reg == RX_BUSY && rx_half_tick) begin
                rx_phase_reg <= !rx_phase_reg;
                if (rx_take) begin
                    rx_sh_reg <= {filt_reg, rx_sh_reg[10:1]};
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                    if ((rx_bit_reg == 4'h0) && filt_reg) begin
                        rx_state_reg <= RX_IDLE; // glitch, not a start bit
                    end else if (rx_bit_reg == FRAME_BITS - 4'h1) begin
                        rx_data_reg <= rx_sh_reg[9:2];
                        stop_ok_reg <= filt_reg;
                        rx_state_reg <= RX_IDLE;
                    end
                end
            end
        end
    end

    // frame-received flag: write one to clear, a new frame wins
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_valid_reg <= 1'b0;
        end else if (rx_take && rx_state_reg == RX_BUSY && rx_bit_reg == FRAME_BITS - 4'h1) begin
            rx_valid_reg <= 1'b1;
        end else if (wr_status && wdata_reg[ST_RX_VALID]) begin
            rx_valid_reg <= 1'b0;
        end
    end
endmodule

/* File: ubrg_props.sv */
module ubrg_props
    import ubrg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register writes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    // serial pins and strobes
    input wire logic rxd,
    input wire logic txd,
    input wire logic base_tick,
    input wire logic tx_half_tick,
    input wire logic rx_half_tick,
    input wire logic rx_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // shadow of the settings, taken when a write is accepted; it may lead
    // the design by a cycle, so the gating checks wait a few cycles
    logic wr_go, pwr, tx_on, rx_on, k8;
    logic [7:0] mode_reg;
    logic [3:0] sel_reg;
    logic [7:0] k_reg;
    logic rxd_reg;
    logic [9:0] rx_quiet_reg;
    logic [9:0] tx_quiet_reg;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign pwr = mode_reg[MODE_POWER_BIT];
    assign tx_on = pwr && mode_reg[MODE_TXE_BIT];
    assign rx_on = pwr && mode_reg[MODE_RXE_BIT];
    assign k8 = k_reg == 8'h08 && sel_reg == 4'h1;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_reg <= 8'h00;
            sel_reg <= SEL_RESET;
            k_reg <= K_RESET;
        end else if (wr_go) begin
            if (s_axi_awaddr == OFS_MODE)
                mode_reg <= s_axi_wdata[7:0];
            if (s_axi_awaddr == OFS_CLKSEL)
                sel_reg <= s_axi_wdata[3:0];
            if (s_axi_awaddr == OFS_DIV)
                k_reg <= s_axi_wdata[7:0];
        end
    end
    // cycles since rxd last fell and since txd was last low, saturating
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rxd_reg <= 1'b1;
            rx_quiet_reg <= 10'h3ff;
            tx_quiet_reg <= 10'h3ff;
        end else begin
            rxd_reg <= rxd;
            rx_quiet_reg <= (rxd_reg && !rxd) ? 10'h000 : rx_quiet_reg + {9'h000, rx_quiet_reg != 10'h3ff};
            tx_quiet_reg <= !txd ? 10'h000 : tx_quiet_reg + {9'h000, tx_quiet_reg != 10'h3ff};
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_base_off: assert property ((!pwr) [*4] |-> !base_tick)
        else $error("base tick while unpowered");
    chk_base_rate: assert property (disable iff (reset || !pwr) $rose(base_tick) && sel_reg == 4'h1 |=> !base_tick ##1 base_tick)
        else $error("base tick period wrong for select 1");
    chk_tx_period: assert property (tx_half_tick && k8 |=> (!tx_half_tick) [*8] ##1 (!tx_half_tick) [*7])
        else $error("tx half tick too early");
    chk_tx_gate: assert property ((!tx_on) [*6] |-> !tx_half_tick && txd)
        else $error("tx divider active while disabled");
    chk_rx_gate: assert property ((!rx_on) [*6] |-> !rx_half_tick)
        else $error("rx divider active while disabled");
    chk_rx_quiet: assert property (rx_half_tick && k8 |-> rx_quiet_reg < 10'h190)
        else $error("rx divider runs outside a frame");
    chk_sample_tick: assert property (rx_sample |-> $past(rx_half_tick) || rx_half_tick)
        else $error("rx sample without half tick");
    chk_tx_start: assert property (wr_go && s_axi_awaddr == OFS_TXBUF && tx_on && k8 && tx_quiet_reg > 10'h190
        |-> ##[1:8] !txd)
        else $error("first byte did not start a frame");
    chk_bad_addr: assert property (wr_go && s_axi_awaddr > OFS_RXDATA |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
endmodule
bind ubrg_top ubrg_props i_props (
    .sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_bvalid, .s_axi_bresp, .rxd, .txd, .base_tick, .tx_half_tick, .rx_half_tick, .rx_sample
);

/* File: ubrg_remote.sv */
module ubrg_remote #(
    parameter int BIT_CYC = 32
) (
    // timing reference
    input wire logic sys_clk,
    // serial lines
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    logic ok_q[$];
    int start_q[$];
    int cyc = 0;
    initial rxd = 1'b1;
    always @(posedge sys_clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////
    // receiver: samples mid-bit and stamps each start for spacing checks
    initial begin
        logic [10:0] f;
        int t0;
        forever begin
            @(negedge txd);
            // stamp at the next edge, where cyc is read before it steps
            @(posedge sys_clk);
            t0 = cyc;
            repeat (BIT_CYC / 2 - 1) @(posedge sys_clk);
            for (int i = 0; i < 11; i++) begin
                f[i] = txd;
                if (i < 10)
                    repeat (BIT_CYC) @(posedge sys_clk);
            end
            start_q.push_back(t0);
            got_q.push_back(f[8:1]);
            ok_q.push_back(!f[0] && f[10] && (^f[9:1] == 1'b0));
        end
    end
    // transmitter at the exact nominal rate, line back to mark after stop
    task automatic send_byte(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk);
            rxd <= f[i];
            repeat (BIT_CYC - 1) @(posedge sys_clk);
        end
    endtask
endmodule

/* File: tb_top.sv */
module tb_top;
    import ubrg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, rxd, txd, base_tick, tx_half_tick, rx_half_tick, rx_sample;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int nb, nt, nr, ns;
    ubrg_top i_dut (
        .sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .rxd, .txd, .base_tick, .tx_half_tick, .rx_half_tick, .rx_sample
    );
    ubrg_remote i_remote (.sys_clk, .txd, .rxd);
    ////////////////////////////////////////////////////////////////
    // clock, and a watchdog so a stuck handshake cannot hang the run
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task finish_test;
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // bus cycles: each channel released at the edge that takes it
    task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // counts strobes over a window of n cycles
    task automatic count(input int n);
        nb = 0;
        nt = 0;
        nr = 0;
        ns = 0;
        repeat (n) begin
            @(posedge sys_clk);
            nb += (base_tick === 1'b1);
            nt += (tx_half_tick === 1'b1);
            nr += (rx_half_tick === 1'b1);
            ns += (rx_sample === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // reset values, readback, unmapped places; k set to 8, the remote's 32 clocks per bit at select 1
    task t_regs;
        axr(OFS_DIV);
        check(rd === {24'h000000, K_RESET} && rs === RESP_OKAY, "ratio reset value");
        axr(OFS_CLKSEL);
        check(rd === {28'h0000000, SEL_RESET}, "select reset value");
        axr(5'h1c);
        check(rd === 32'h00000000 && rs === RESP_SLVERR, "unmapped read");
        axw(5'h18, 32'h000000ff);
        check(rs === RESP_SLVERR, "unmapped write");
        axw(OFS_DIV, 32'h00000008);
        axr(OFS_DIV);
        check(rd === 32'h00000008, "ratio readback");
    endtask
    // base tick for several sources; source changed only while unpowered
    task t_rate;
        for (int s = 0; s < 4; s++) begin
            axw(OFS_MODE, 32'h00000000);
            count(64);
            check(nb === 0 && nt === 0, "ticks while unpowered");
            axw(OFS_CLKSEL, 32'(s));
            axw(OFS_MODE, 32'h00000080);
            count(16);
            count(64);
            check(nb === (64 >> s), "base tick rate");
        end
        axw(OFS_MODE, 32'h00000000);
        axw(OFS_CLKSEL, 32'h00000001);
    endtask
    // enable gating; rx waits for a start bit even when enabled
    task t_gate;
        axw(OFS_MODE, 32'h00000080);
        count(200);
        check(nt === 0 && nr === 0, "dividers run while disabled");
        axw(OFS_MODE, 32'h000000e0);
        count(32);
        count(320);
        check(nt === 20 && nr === 0, "tx free run, rx idle");
    endtask
    // second byte queued while the first one shifts out
    task t_tx;
        axw(OFS_TXBUF, 32'h000000a5);
        axw(OFS_TXBUF, 32'h0000003c);
        count(800);
        check(i_remote.got_q.size() === 2, "frame count");
        check(i_remote.got_q[0] === 8'ha5 && i_remote.got_q[1] === 8'h3c, "sent bytes");
        check(i_remote.ok_q[0] === 1'b1 && i_remote.ok_q[1] === 1'b1, "framing or parity");
        check(i_remote.start_q[1] - i_remote.start_q[0] === 11 * 32 + 4, "back-to-back spacing");
        count(320);
        check(nt === 20, "tx counter not counting after last frame");
    endtask
    // one frame in from the far side
    task t_rx;
        fork
            i_remote.send_byte(8'h5a);
            count(480);
        join
        check(ns === 11, "samples per frame");
        axr(OFS_RXDATA);
        check(rd === 32'h0000005a, "received byte");
        axr(OFS_STATUS);
        check(rd[1:0] === 2'b11, "frame done with stop bit");
        count(320);
        check(nr === 0, "rx counter runs after the frame");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 5'h00;
        s_axi_araddr = 5'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_rate();
        t_gate();
        t_tx();
        t_rx();
        finish_test();
    end
endmodule
